// file: rtl/pnpim_top.sv
// Next-page transmit and interrupt mask register bank on APB
// Word map, byte address is the word index times four:
//    0x1C next-page transmit word
//    0x40 interrupt enable mask, bits 15:12
//    0x44 interrupt status, bits 15:12, cleared when read
//    0x70 legacy compatibility control, bit 0
// All transfers finish without wait states. An unmapped or misaligned
// word answers with an error and reads as zero; its writes are lost.
`default_nettype none
`timescale 1ns/100ps

module pnpim_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pnpim_pkg::ADDR_W-1:0] paddr,
   input wire logic [pnpim_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [pnpim_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Status from auto-negotiation logic
   input wire logic linkAckIn,
   input wire logic linkToggleIn,
   // Event pulses from receive logic
   input wire logic carrierMonitorUnstable,
   input wire logic linkStatusChange,
   input wire logic descramblerLockChange,
   input wire logic prematureEndError,
   // Toward auto-negotiation logic
   output logic [pnpim_pkg::REG_W-1:0] nextPageWord,
   output logic legacyMode,
   // Interrupt
   output logic irq
);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic [pnpim_pkg::ADDR_W-1:0] wordIdx;
   logic aligned;
   logic setupPhase;
   logic accessPhase;
   logic hitNextPage;
   logic hitMask;
   logic hitStatus;
   logic hitLegacy;
   logic mapped;
   logic wrLow;
   logic wrHigh;

   // Index is the byte address divided by four
   assign wordIdx = paddr >> pnpim_pkg::IDX_SHIFT;
   assign aligned =
      (paddr[pnpim_pkg::IDX_SHIFT-1:0] == pnpim_pkg::WORD_LSB_ZERO);
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   assign hitNextPage = aligned & (wordIdx == pnpim_pkg::IDX_NEXT_PAGE_TX);
   assign hitMask = aligned & (wordIdx == pnpim_pkg::IDX_IRQ_MASK);
   assign hitStatus = aligned & (wordIdx == pnpim_pkg::IDX_IRQ_STATUS);
   assign hitLegacy = aligned & (wordIdx == pnpim_pkg::IDX_LEGACY_CFG);
   assign mapped = hitNextPage | hitMask | hitStatus | hitLegacy;

   // Registers are 16 bits, so only the two low byte lanes matter
   assign wrLow = accessPhase & pwrite & pstrb[pnpim_pkg::LANE_LO];
   assign wrHigh = accessPhase & pwrite & pstrb[pnpim_pkg::LANE_HI];

   // Zero wait states; unmapped or misaligned access reports an error
   assign pready = 1'b1;
   assign pslverr = accessPhase & ~mapped;

   // ---------------------------------------------------------------
   // Software-writable state
   // ---------------------------------------------------------------
   logic moreNext_q;
   logic moreNext_d;
   logic msgPage_q;
   logic msgPage_d;
   logic ack2_q;
   logic ack2_d;
   logic [pnpim_pkg::CODE_W-1:0] code_q;
   logic [pnpim_pkg::CODE_W-1:0] code_d;
   logic [pnpim_pkg::EVT_W-1:0] mask_q;
   logic [pnpim_pkg::EVT_W-1:0] mask_d;
   logic legacy_q;
   logic legacy_d;
   logic npWrLow;
   logic npWrHigh;
   logic maskWrHigh;

   // Legacy mode freezes the next-page and mask fields
   assign npWrLow = wrLow & hitNextPage & ~legacy_q;
   assign npWrHigh = wrHigh & hitNextPage & ~legacy_q;
   assign maskWrHigh = wrHigh & hitMask & ~legacy_q;

   // Next values of the writable fields
   always_comb begin
      moreNext_d = moreNext_q;
      msgPage_d = msgPage_q;
      ack2_d = ack2_q;
      code_d = code_q;
      mask_d = mask_q;
      legacy_d = legacy_q;
      // Upper lane: the flags and the top of the code field
      if (npWrHigh) begin
         moreNext_d = pwdata[pnpim_pkg::NP_MORE_BIT];
         msgPage_d = pwdata[pnpim_pkg::NP_MSG_BIT];
         ack2_d = pwdata[pnpim_pkg::NP_ACK2_BIT];
         code_d[pnpim_pkg::CODE_W-1:pnpim_pkg::LANE_W] =
            pwdata[pnpim_pkg::NP_CODE_MSB:pnpim_pkg::LANE_W];
      end
      // Lower lane: the rest of the code field
      if (npWrLow) begin
         code_d[pnpim_pkg::LANE_W-1:0] =
            pwdata[pnpim_pkg::LANE_W-1:pnpim_pkg::NP_CODE_LSB];
      end
      // Only the upper event group exists; the lower lane is dropped
      if (maskWrHigh) begin
         mask_d = pwdata[pnpim_pkg::EVT_LSB+pnpim_pkg::EVT_W-1:
                         pnpim_pkg::EVT_LSB];
      end
      // Legacy bit stays writable, or the mode could never be left
      if (wrLow & hitLegacy) begin
         legacy_d = pwdata[pnpim_pkg::LEGACY_BIT];
      end
   end

   // Register stage with documented reset values
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         moreNext_q <= pnpim_pkg::NP_MORE_RST;
         msgPage_q <= pnpim_pkg::NP_MSG_RST;
         ack2_q <= pnpim_pkg::NP_ACK2_RST;
         code_q <= pnpim_pkg::NP_CODE_RST;
         mask_q <= pnpim_pkg::MASK_RST;
         legacy_q <= pnpim_pkg::LEGACY_RST;
      end else begin
         moreNext_q <= moreNext_d;
         msgPage_q <= msgPage_d;
         ack2_q <= ack2_d;
         code_q <= code_d;
         mask_q <= mask_d;
         legacy_q <= legacy_d;
      end
   end

   // ---------------------------------------------------------------
   // Device-supplied status bits
   // ---------------------------------------------------------------
   logic linkAck_q;
   logic linkAck_d;
   logic toggle_q;
   logic toggle_d;

   // Host writes never reach these two bits; they only mirror the link
   // Same-clock inputs, so no synchroniser; registered for clean reads
   always_comb begin
      linkAck_d = linkAckIn;
      toggle_d = linkToggleIn;
   end

   // Register stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         linkAck_q <= pnpim_pkg::NP_ACK_RST;
         toggle_q <= pnpim_pkg::NP_TOGGLE_RST;
      end else begin
         linkAck_q <= linkAck_d;
         toggle_q <= toggle_d;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status and pin
   // ---------------------------------------------------------------
   logic [pnpim_pkg::EVT_W-1:0] eventVec;
   logic [pnpim_pkg::EVT_W-1:0] status;
   logic statusRead;
   logic irq_q;
   logic irq_d;

   // Events are collected regardless of the mask
   always_comb begin
      eventVec = '0;
      eventVec[pnpim_pkg::EVT_CARRIER_UNSTABLE] = carrierMonitorUnstable;
      eventVec[pnpim_pkg::EVT_LINK_CHANGE] = linkStatusChange;
      eventVec[pnpim_pkg::EVT_DESCR_LOCK] = descramblerLockChange;
      eventVec[pnpim_pkg::EVT_PREM_END] = prematureEndError;
   end

   // Clear happens on the completing edge of a status read
   assign statusRead = accessPhase & ~pwrite & hitStatus;

   pnpim_event_latch #(
      .W(pnpim_pkg::EVT_W)
   ) u_status (
      .clk_sys(clk_sys),
      .reset(reset),
      .eventPulse(eventVec),
      .clearAll(statusRead),
      .latched(status)
   );

   // Pin follows the status seen one edge earlier; a trade for a clean flop
   always_comb begin
      // A masked event waits in status and fires once its mask is set
      irq_d = |(status & mask_q);
   end

   // Register stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_q <= pnpim_pkg::IRQ_RST;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign irq = irq_q;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [pnpim_pkg::REG_W-1:0] npWord;
   logic [pnpim_pkg::DATA_W-1:0] rdata_q;
   logic [pnpim_pkg::DATA_W-1:0] rdata_d;

   // Assembled next-page word, also handed to the negotiation logic
   always_comb begin
      npWord = '0;
      npWord[pnpim_pkg::NP_MORE_BIT] = moreNext_q;
      npWord[pnpim_pkg::NP_ACK_BIT] = linkAck_q;
      npWord[pnpim_pkg::NP_MSG_BIT] = msgPage_q;
      npWord[pnpim_pkg::NP_ACK2_BIT] = ack2_q;
      npWord[pnpim_pkg::NP_TOGGLE_BIT] = toggle_q;
      npWord[pnpim_pkg::NP_CODE_MSB:pnpim_pkg::NP_CODE_LSB] = code_q;
   end

   // Read mux captured in setup so data comes from a flop in access
   always_comb begin
      rdata_d = rdata_q;
      if (setupPhase) begin
         // Each transfer starts from zero: unmapped words read as zero
         rdata_d = '0;
         if (!pwrite) begin
            if (hitNextPage) begin
               rdata_d[pnpim_pkg::REG_W-1:0] = npWord;
            end
            if (hitMask) begin
               rdata_d[pnpim_pkg::EVT_LSB+pnpim_pkg::EVT_W-1:
                       pnpim_pkg::EVT_LSB] = mask_q;
            end
            if (hitStatus) begin
               rdata_d[pnpim_pkg::EVT_LSB+pnpim_pkg::EVT_W-1:
                       pnpim_pkg::EVT_LSB] = status;
            end
            if (hitLegacy) begin
               rdata_d[pnpim_pkg::LEGACY_BIT] = legacy_q;
            end
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Read data from its flop; the word reaches the negotiation side as is
   assign prdata = rdata_q;
   assign nextPageWord = npWord;
   assign legacyMode = legacy_q;

endmodule : pnpim_top

`default_nettype wire

// file: include/pnpim_pkg.sv
// Constants for the next-page transmit and interrupt mask register bank
`default_nettype none

package pnpim_pkg;

   // ---------------------------------------------------------------
   // Bus and register geometry
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned REG_W = 16;
   localparam int unsigned EVT_W = 4;
   localparam int unsigned CODE_W = 11;

   // Register indices as printed; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_NEXT_PAGE_TX = 12'h007;
   localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h010;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h011;
   localparam logic [ADDR_W-1:0] IDX_LEGACY_CFG = 12'h01C;
   localparam logic [1:0] WORD_LSB_ZERO = 2'h0;
   localparam int unsigned IDX_SHIFT = 2;

   // Byte lanes of the 16-bit registers; lane 1 holds bits 15:8
   localparam int unsigned LANE_W = 8;
   localparam int unsigned LANE_LO = 0;
   localparam int unsigned LANE_HI = 1;

   // ---------------------------------------------------------------
   // Next-page transmit word fields
   // ---------------------------------------------------------------
   localparam int unsigned NP_MORE_BIT = 15;
   localparam int unsigned NP_ACK_BIT = 14;
   localparam int unsigned NP_MSG_BIT = 13;
   localparam int unsigned NP_ACK2_BIT = 12;
   localparam int unsigned NP_TOGGLE_BIT = 11;
   localparam int unsigned NP_CODE_MSB = 10;
   localparam int unsigned NP_CODE_LSB = 0;

   localparam logic NP_MORE_RST = 1'h0;
   localparam logic NP_MSG_RST = 1'h1;
   localparam logic NP_ACK2_RST = 1'h0;
   localparam logic [CODE_W-1:0] NP_CODE_RST = 11'h001;
   localparam logic NP_ACK_RST = 1'h0;
   localparam logic NP_TOGGLE_RST = 1'h0;

   // ---------------------------------------------------------------
   // Interrupt mask and status fields (upper event group)
   // ---------------------------------------------------------------
   localparam int unsigned EVT_LSB = 12;
   localparam int unsigned EVT_PREM_END = 0;
   localparam int unsigned EVT_DESCR_LOCK = 1;
   localparam int unsigned EVT_LINK_CHANGE = 2;
   localparam int unsigned EVT_CARRIER_UNSTABLE = 3;

   // Bit 15 carrier unstable, 14 link change, 13 descrambler, 12 end error
   localparam logic [EVT_W-1:0] MASK_RST = 4'h4;

   // Legacy compatibility control
   localparam int unsigned LEGACY_BIT = 0;
   localparam logic LEGACY_RST = 1'h0;

   // Interrupt pin level out of reset
   localparam logic IRQ_RST = 1'h0;

endpackage : pnpim_pkg

`default_nettype wire

// file: rtl/pnpim_event_latch.sv
// Sticky event latch with clear-on-read, set wins over clear
`default_nettype none
`timescale 1ns/100ps

module pnpim_event_latch #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Event side
   input wire logic [W-1:0] eventPulse,
   // Software side
   input wire logic clearAll,
   output logic [W-1:0] latched
);

   logic [W-1:0] latch_q;
   logic [W-1:0] latch_d;

   // Clear first, then OR in new events so a same-cycle event survives
   always_comb begin
      latch_d = latch_q;
      if (clearAll) begin
         latch_d = '0;
      end
      latch_d = latch_d | eventPulse;
   end

   // Register stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         latch_q <= '0;
      end else begin
         latch_q <= latch_d;
      end
   end

   assign latched = latch_q;

endmodule : pnpim_event_latch

`default_nettype wire

// file: sim/pnpim_checker.sv
// Port assertions for the next-page and interrupt mask bank
`default_nettype none
`timescale 1ns/100ps

module pnpim_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pnpim_pkg::ADDR_W-1:0] paddr,
   input wire logic [pnpim_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [pnpim_pkg::DATA_W-1:0] prdata,
   // Link and event side
   input wire logic linkAckIn,
   input wire logic linkToggleIn,
   input wire logic carrierMonitorUnstable,
   input wire logic linkStatusChange,
   input wire logic descramblerLockChange,
   input wire logic prematureEndError,
   input wire logic [pnpim_pkg::REG_W-1:0] nextPageWord,
   input wire logic legacyMode,
   input wire logic irq
);
   localparam logic [11:0] ANP = pnpim_pkg::IDX_NEXT_PAGE_TX << 2;
   localparam logic [11:0] AST = pnpim_pkg::IDX_IRQ_STATUS << 2;
   logic wrAny;
   logic wrNp;
   logic anyEvt;
   logic [13:0] npRw;
   // Decode shared by the properties
   assign wrAny = psel && penable && pwrite;
   assign wrNp = wrAny && paddr == ANP;
   assign anyEvt = carrierMonitorUnstable || linkStatusChange
      || descramblerLockChange || prematureEndError;
   // Writable fields only; ack and toggle follow the link logic
   assign npRw = {nextPageWord[15], nextPageWord[13:12], nextPageWord[10:0]};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_ack;
      1 |=> nextPageWord[14] == $past(linkAckIn);
   endproperty
   a_ack: assert property (p_ack) else $error("ack bit wrong");
   property p_tog;
      1 |=> nextPageWord[11] == $past(linkToggleIn);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle bit wrong");
   property p_npwr;
      wrNp && !legacyMode && pstrb == 4'hF |=>
         npRw == $past({pwdata[15], pwdata[13:12], pwdata[10:0]});
   endproperty
   a_npwr: assert property (p_npwr)
      else $error("np write lost");
   property p_leg;
      wrNp && legacyMode |=> $stable(npRw);
   endproperty
   a_leg: assert property (p_leg) else $error("legacy write taken");
   property p_rst;
      $fell(reset) |-> nextPageWord == 16'h2001;
   endproperty
   a_rst: assert property (p_rst)
      else $error("np reset value");
   property p_rdnp;
      psel && !penable && !pwrite && paddr == ANP |=>
         prdata == {16'h0000, $past(nextPageWord)};
   endproperty
   a_rdnp: assert property (p_rdnp) else $error("np read data");
   property p_clr;
      psel && penable && !pwrite && paddr == AST && !anyEvt |=> ##1 !irq;
   endproperty
   a_clr: assert property (p_clr)
      else $error("irq after clear");
   property p_cause;
      $rose(irq) |-> $past(anyEvt, 2) || $past(wrAny, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("irq no cause");
endmodule : pnpim_checker

bind pnpim_top pnpim_checker chk_u (.clk_sys, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .linkAckIn, .linkToggleIn,
   .carrierMonitorUnstable, .linkStatusChange, .descramblerLockChange,
   .prematureEndError, .nextPageWord, .legacyMode, .irq);

`default_nettype wire

// file: sim/pnpim_host.sv
// Management host model issuing APB transfers
`default_nettype none
`timescale 1ns/100ps

module pnpim_host (
   // Clock
   input wire logic clk_sys,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero; all byte lanes until told otherwise
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
   end

   // One transfer; an edge always passes before a new setup
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer

   // Byte lanes for later writes; called only while the bus is idle
   task automatic lanes(input logic [3:0] s);
      pstrb <= s;
   endtask : lanes
endmodule : pnpim_host

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the next-page and interrupt mask bank
`default_nettype none
`timescale 1ns/100ps

module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, legacyMode, irq, err;
   logic linkAckIn = 1'b0;
   logic linkToggleIn = 1'b0;
   logic [3:0] evt = 4'h0;
   logic [3:0] pstrb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] nextPageWord;
   int errCount = 0;
   int checksDone = 0;
   localparam logic [11:0] ANP = pnpim_pkg::IDX_NEXT_PAGE_TX << 2;
   localparam logic [11:0] AMK = pnpim_pkg::IDX_IRQ_MASK << 2;
   localparam logic [11:0] AST = pnpim_pkg::IDX_IRQ_STATUS << 2;
   localparam logic [11:0] ALG = pnpim_pkg::IDX_LEGACY_CFG << 2;

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   pnpim_top dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .linkAckIn,
      .linkToggleIn, .carrierMonitorUnstable(evt[3]),
      .linkStatusChange(evt[2]), .descramblerLockChange(evt[1]),
      .prematureEndError(evt[0]), .nextPageWord, .legacyMode, .irq);
   pnpim_host host_u (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      host_u.xfer(1'b0, a, 32'h00000000, rd, err);
      chk(rd, exp);
   endtask : rdChk
   task automatic finishTest();
      $display("Checks %0d, errors %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finishTest

   // Values straight out of reset
   task automatic t_reset();
      rdChk(ANP, 32'h00002001);
      rdChk(AMK, 32'h00004000);
      rdChk(AST, 32'h00000000);
   endtask : t_reset
   // Writable fields take data, read-only bits follow the link side
   task automatic t_np();
      wr(ANP, 32'h0000FFFF);
      rdChk(ANP, 32'h0000B7FF);
      linkAckIn <= 1'b1;
      linkToggleIn <= 1'b1;
      wr(ANP, 32'h00000000);
      rdChk(ANP, 32'h00004800);
      linkAckIn <= 1'b0;
      linkToggleIn <= 1'b0;
      wr(ANP, 32'h00002001);
      // Single byte lanes touch only their own bits
      host_u.lanes(4'h1);
      wr(ANP, 32'h0000DAAA);
      rdChk(ANP, 32'h000020AA);
      host_u.lanes(4'h2);
      wr(ANP, 32'h0000DD55);
      rdChk(ANP, 32'h000095AA);
      host_u.lanes(4'hF);
      wr(ANP, 32'h00002001);
   endtask : t_np
   // Each event once; pin follows mask, status always records
   task automatic t_irq(input logic [3:0] m);
      wr(AMK, {16'h0000, m, 12'h000});
      rdChk(AMK, {16'h0000, m, 12'h000});
      for (int i = 0; i < 4; i++) begin
         evt[i] <= 1'b1;
         @(posedge clk_sys);
         evt[i] <= 1'b0;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk({31'h0, irq}, {31'h0, m[i]});
         rdChk(AST, 32'h1 << (12 + i));
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk({31'h0, irq}, 32'h0);
         rdChk(AST, 32'h0);
      end
   endtask : t_irq
   // Legacy mode freezes the next-page and mask fields
   task automatic t_legacy();
      wr(ALG, 32'h00000001);
      wr(ANP, 32'h00000000);
      @(negedge clk_sys);
      chk({31'h0, legacyMode}, 32'h1);
      chk({16'h0, nextPageWord}, 32'h2001);
      wr(AMK, 32'h00000000);
      rdChk(AMK, 32'h0000F000);
      wr(ALG, 32'h00000000);
   endtask : t_legacy
   // Unmapped place answers with an error and zero data
   task automatic t_err();
      host_u.xfer(1'b0, 12'h004, 32'h00000000, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_err
   // Mid-run reset brings back every default and drops pending events
   task automatic t_rst();
      wr(ANP, 32'h0000FFFF);
      wr(ALG, 32'h00000001);
      evt <= 4'hF;
      @(posedge clk_sys);
      evt <= 4'h0;
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, legacyMode}, 32'h0);
      rdChk(ANP, 32'h00002001);
      rdChk(AMK, 32'h00004000);
      rdChk(AST, 32'h00000000);
   endtask : t_rst

   // Main sequence after three reset cycles
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_np();
      t_irq(4'h4);
      t_irq(4'hF);
      t_legacy();
      t_err();
      t_rst();
      finishTest();
   end
   // Watchdog, well beyond the fewer than two hundred cycles needed
   initial begin
      #20000;
      errCount++;
      finishTest();
   end
endmodule : testbench

`default_nettype wire
